/* File: logic/bus_width_idle_config_defines.vh */
// Constants for the bus width and idle cycle configuration block
// How it works
// [R1] Width register 16-bit, resets 0x3ffc, power-on only
// [R2] Width bits 15, 14, 1 read zero
// [R3] Per-area size code: byte, halfword, word
// [R4] Port enable frees lanes 23-16; word reserved
// [R5] Software sets narrow widths before port enable
// [R6] Only area 0 used before width setup
// [R7] Idle register 16-bit, resets 0x3fff, power-on only
// [R8] Idle cycles inserted against bus contention
// [R9] Idle field of area left applies
// [R10] Idle codes give 1, 1, 2, 3 cycles
// [R11] Wait select picks rising or falling sample
// [R12] Wait synchronous when rising edge sampling
// [R13] Idle bit 14 reads zero
// [R14] Idle counted in bus clocks, strobes off
`ifndef BUS_WIDTH_IDLE_CONFIG_DEFINES_VH
`define BUS_WIDTH_IDLE_CONFIG_DEFINES_VH

// Register byte addresses on the slave bus
`define ADDR_BUS_WIDTH 4'h0
`define ADDR_IDLE_CTRL 4'h4

// Reset values
`define BUS_WIDTH_RESET 16'h3ffc
`define IDLE_CTRL_RESET 16'h3fff

// Writable bit masks
`define BUS_WIDTH_MASK 16'h3ffd
`define IDLE_CTRL_MASK 16'hbfff

// Field positions
`define PORT_EN_BIT 0
`define WAIT_SEL_BIT 15

// Size codes
`define SIZE_RSVD 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_HALF 2'h2
`define SIZE_WORD 2'h3

// Idle counts per code
`define IDLE_CODE_00 2'h1
`define IDLE_CODE_01 2'h1
`define IDLE_CODE_10 2'h2
`define IDLE_CODE_11 2'h3

`endif

/* File: logic/bus_width_idle_config.v */
// Bus width and idle cycle configuration with external access sequencer
`timescale 1ns/1ns
`include "bus_width_idle_config_defines.vh"

module bus_width_idle_config #(
	parameter CLK_HALF = 2,
	parameter NUM_AREAS = 7
) (
	// Clock and power-on reset
	input wire mclk_i,
	input wire rst_i,
	// Manual reset: sequencer only, registers keep contents
	input wire manual_rst_i,
	// Avalon-MM slave
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output wire [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// Internal access request
	input wire acc_req_i,
	input wire [2:0] acc_area_i,
	input wire acc_write_i,
	output wire acc_ack_o,
	// External bus
	output wire bus_clock_out_o,
	output wire [6:0] chip_select_n_o,
	output wire read_strobe_n_o,
	output wire write_strobe_n_o,
	input wire wait_n_i,
	output wire [1:0] access_width_o,
	// Upper byte lanes and configuration status
	output wire upper_byte_port_enable_o,
	output wire data_lines_23_to_16_bus_o,
	output wire width_reserved_o,
	output wire width_initialised_o
);

	reg [15:0] area_bus_width_control_reg;
	reg [15:0] idle_cycle_control_reg;
	reg ack_reg;
	reg [31:0] rdata_reg;
	reg init_reg;

	wire req;
	wire take;
	wire hit_width;
	wire hit_idle;
	wire [15:0] wdata16;
	wire [15:0] lane_mask;

	assign req = avs_read_i | avs_write_i;
	// One wait cycle, then the answer
	assign avs_waitrequest_o = req & ~ack_reg;
	assign take = req & ack_reg;
	assign hit_width = (avs_address_i == `ADDR_BUS_WIDTH);
	assign hit_idle = (avs_address_i == `ADDR_IDLE_CTRL);
	assign wdata16 = avs_writedata_i[15:0];
	assign lane_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign avs_readdata_o = rdata_reg;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// Read data settles in the cycle waitrequest drops
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h00000000;
		end else if (avs_read_i & ~ack_reg) begin
			if (hit_width) begin
				// [R2] Reserved bits zero
				rdata_reg <= {16'h0000, area_bus_width_control_reg & `BUS_WIDTH_MASK};
			end else if (hit_idle) begin
				// [R13] Bit 14 zero
				rdata_reg <= {16'h0000, idle_cycle_control_reg & `IDLE_CTRL_MASK};
			end else begin
				rdata_reg <= 32'h00000000;
			end
		end
	end

	// [R1] Power-on reset only
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			area_bus_width_control_reg <= `BUS_WIDTH_RESET;
		end else if (take & avs_write_i & hit_width) begin
			// [R2] Reserved bits forced zero
			area_bus_width_control_reg <= ((area_bus_width_control_reg & ~lane_mask) |
				(wdata16 & lane_mask)) & `BUS_WIDTH_MASK;
		end
	end

	// [R7] Power-on reset only
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_cycle_control_reg <= `IDLE_CTRL_RESET;
		end else if (take & avs_write_i & hit_idle) begin
			// [R13] Bit 14 forced zero
			idle_cycle_control_reg <= ((idle_cycle_control_reg & ~lane_mask) |
				(wdata16 & lane_mask)) & `IDLE_CTRL_MASK;
		end
	end

	// [R6] Flags that software has set up the widths
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			init_reg <= 1'b0;
		end else if (take & avs_write_i & hit_width) begin
			init_reg <= 1'b1;
		end
	end
	assign width_initialised_o = init_reg;

	// [R4] Port mode takes over lanes 23-16
	wire port_en;
	assign port_en = area_bus_width_control_reg[`PORT_EN_BIT];
	assign upper_byte_port_enable_o = port_en;
	assign data_lines_23_to_16_bus_o = ~port_en;

	// [R3] Per-area reserved size detection
	wire [6:1] area_rsvd;
	genvar g;
	generate
		for (g = 1; g < 7; g = g + 1) begin : g_size
			wire [1:0] code;
			assign code = area_bus_width_control_reg[2*g+1:2*g];
			// [R5] Word while port enabled is a software fault
			assign area_rsvd[g] = (code == `SIZE_RSVD) |
				(port_en & (code == `SIZE_WORD));
		end
	endgenerate
	assign width_reserved_o = |area_rsvd;

	// Bus clock divider: one period is two half phases of CLK_HALF cycles
	reg [7:0] div_reg;
	reg bclk_reg;
	wire half_done;
	wire rise_ev;
	wire fall_ev;
	assign half_done = (div_reg == CLK_HALF[7:0] - 8'h01);
	assign rise_ev = half_done & ~bclk_reg;
	assign fall_ev = half_done & bclk_reg;
	assign bus_clock_out_o = bclk_reg;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			div_reg <= 8'h00;
			bclk_reg <= 1'b0;
		end else if (half_done) begin
			div_reg <= 8'h00;
			bclk_reg <= ~bclk_reg;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// [R11] Wait sampled on the selected bus clock edge
	reg wait_seen_reg;
	wire wait_sel;
	assign wait_sel = idle_cycle_control_reg[`WAIT_SEL_BIT];

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_seen_reg <= 1'b0;
		end else if ((rise_ev & ~wait_sel) | (fall_ev & wait_sel)) begin
			// [R12] Input treated as already synchronous here
			wait_seen_reg <= ~wait_n_i;
		end
	end

	// Access sequencer state
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_GAP = 2'h1;
	localparam [1:0] ST_ACCESS = 2'h2;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [2:0] last_area_reg;
	reg last_read_reg;
	reg last_valid_reg;
	reg [1:0] gap_reg;
	reg [2:0] cur_area_reg;
	reg cur_write_reg;
	reg ack_pulse_reg;
	reg [6:0] cs_n_reg;
	reg rd_n_reg;
	reg wr_n_reg;
	reg [1:0] width_reg;

	// [R10] Idle count decode of the area being left
	reg [1:0] idle_field;
	reg [1:0] idle_count;
	always @* begin
		idle_field = 2'h0;
		if (last_area_reg < NUM_AREAS) begin
			// [R9] Field of the previous area
			idle_field = idle_cycle_control_reg[last_area_reg*2 +: 2];
		end
		case (idle_field)
			2'h0: idle_count = `IDLE_CODE_00;
			2'h1: idle_count = `IDLE_CODE_01;
			2'h2: idle_count = `IDLE_CODE_10;
			default: idle_count = `IDLE_CODE_11;
		endcase
	end

	// [R8] Gap when changing area or read then write
	wire need_gap;
	assign need_gap = last_valid_reg & ((acc_area_i != last_area_reg) |
		(last_read_reg & acc_write_i));

	// Width of a requested area; area 0 has no field here and runs as word
	reg [1:0] req_width;
	always @* begin
		req_width = `SIZE_WORD;
		if ((acc_area_i != 3'h0) & (acc_area_i < NUM_AREAS)) begin
			req_width = area_bus_width_control_reg[acc_area_i*2 +: 2];
		end
	end

	// [R11] Rising mode uses the level at this rise, else the one caught at the fall
	wire wait_now;
	wire access_end;
	assign wait_now = wait_sel ? wait_seen_reg : ~wait_n_i;
	assign access_end = rise_ev & ~wait_now;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (rise_ev & acc_req_i) begin
					if (need_gap) begin
						state_next = ST_GAP;
					end else begin
						state_next = ST_ACCESS;
					end
				end
			end
			ST_GAP: begin
				if (rise_ev & (gap_reg == 2'h1)) begin
					state_next = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (access_end) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Manual reset restarts the sequencer but leaves the registers
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			gap_reg <= 2'h0;
			last_area_reg <= 3'h0;
			last_read_reg <= 1'b0;
			last_valid_reg <= 1'b0;
			cur_area_reg <= 3'h0;
			cur_write_reg <= 1'b0;
			ack_pulse_reg <= 1'b0;
			width_reg <= 2'h0;
		end else if (manual_rst_i) begin
			state_reg <= ST_IDLE;
			gap_reg <= 2'h0;
			last_valid_reg <= 1'b0;
			ack_pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ack_pulse_reg <= 1'b0;
			if ((state_reg == ST_IDLE) & rise_ev & acc_req_i) begin
				cur_area_reg <= acc_area_i;
				cur_write_reg <= acc_write_i;
				width_reg <= req_width;
				// [R14] Count in bus clock periods
				gap_reg <= idle_count;
			end else if ((state_reg == ST_GAP) & rise_ev) begin
				gap_reg <= gap_reg - 2'h1;
			end
			if ((state_reg == ST_ACCESS) & access_end) begin
				last_area_reg <= cur_area_reg;
				last_read_reg <= ~cur_write_reg;
				last_valid_reg <= 1'b1;
				ack_pulse_reg <= 1'b1;
			end
		end
	end
	assign acc_ack_o = ack_pulse_reg;

	// [R14] Strobes only in the access state
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_n_reg <= 7'h7f;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
		end else if (state_next == ST_ACCESS && !manual_rst_i) begin
			cs_n_reg <= ~(7'h01 << cur_sel(state_reg, acc_area_i, cur_area_reg));
			rd_n_reg <= cur_wr(state_reg, acc_write_i, cur_write_reg);
			wr_n_reg <= ~cur_wr(state_reg, acc_write_i, cur_write_reg);
		end else begin
			cs_n_reg <= 7'h7f;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
		end
	end

	// Area of the access about to run, new or held
	function [2:0] cur_sel;
		input [1:0] st;
		input [2:0] new_area;
		input [2:0] held_area;
		begin
			if (st == ST_IDLE) begin
				cur_sel = new_area;
			end else begin
				cur_sel = held_area;
			end
		end
	endfunction

	function cur_wr;
		input [1:0] st;
		input new_wr;
		input held_wr;
		begin
			if (st == ST_IDLE) begin
				cur_wr = new_wr;
			end else begin
				cur_wr = held_wr;
			end
		end
	endfunction

	assign chip_select_n_o = cs_n_reg;
	assign read_strobe_n_o = rd_n_reg;
	assign write_strobe_n_o = wr_n_reg;
	assign access_width_o = width_reg;

endmodule

/* File: verification/bus_width_idle_config_checker.sv */
// Port-level assertions for the bus width and idle configuration block
`timescale 1ns/1ns
module bus_width_idle_config_checker (
	// Clock, reset and slave bus
	input wire mclk_i,
	input wire rst_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	// External bus and status
	input wire [6:0] chip_select_n_o,
	input wire read_strobe_n_o,
	input wire write_strobe_n_o,
	input wire upper_byte_port_enable_o,
	input wire data_lines_23_to_16_bus_o,
	input wire width_initialised_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence rd_done(a);
		avs_read_i && !avs_waitrequest_o && avs_address_i == a;
	endsequence
	sequence wr_done;
		avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0;
	endsequence
	sequence rd_end;
		$rose(read_strobe_n_o);
	endsequence
	AST_WIDTH_RSVD:
	assert property (rd_done(4'h0) |-> avs_readdata_o[15:14] == 2'h0 && !avs_readdata_o[1])
		else $error("width reserved bits read nonzero");
	AST_IDLE_RSVD:
	assert property (rd_done(4'h4) |-> !avs_readdata_o[14]) else $error("idle bit 14 nonzero");
	AST_PORT_EN:
	assert property (wr_done ##0 avs_byteenable_i[0]
		|=> upper_byte_port_enable_o == $past(avs_writedata_i[0])) else $error("port enable");
	AST_LANES:
	assert property (data_lines_23_to_16_bus_o != upper_byte_port_enable_o)
		else $error("lanes not inverse of port enable");
	AST_INIT_FLAG:
	assert property (wr_done |=> width_initialised_o) else $error("init flag not set");
	AST_POR_CLEAR:
	assert property ($fell(rst_i) |-> !upper_byte_port_enable_o && !width_initialised_o)
		else $error("status not cleared by reset");
	AST_STROBE_CS:
	assert property (!(read_strobe_n_o && write_strobe_n_o)
		|-> chip_select_n_o != 7'h7f && $onehot0(~chip_select_n_o)) else $error("strobe sans cs");
	// Holds for a bus clock of at least four system clocks
	AST_READ_WRITE_GAP:
	assert property (rd_end |-> write_strobe_n_o [*8]) else $error("write too soon after read");
endmodule

bind bus_width_idle_config bus_width_idle_config_checker u_checker (.mclk_i, .rst_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
	.avs_readdata_o, .avs_waitrequest_o, .chip_select_n_o, .read_strobe_n_o,
	.write_strobe_n_o, .upper_byte_port_enable_o, .data_lines_23_to_16_bus_o,
	.width_initialised_o);

/* File: verification/ext_memory_model.sv */
// External memory that can stretch an access with its wait line
`timescale 1ns/1ns
module ext_memory_model (
	input wire bus_clock_out_i,
	input wire [6:0] chip_select_n_i,
	input wire slow_i,
	output logic wait_n_o
);
	int n = 0;
	// Falls counted while selected; wait drops with the select so
	// that either sampling edge sees it, and rises after the third fall
	always @(negedge bus_clock_out_i) begin
		if (&chip_select_n_i) begin
			n = 0;
		end else begin
			n++;
		end
	end
	// Deselected, the line shows its pull-up level
	assign wait_n_o = !(slow_i && !(&chip_select_n_i) && n < 3);
endmodule

/* File: verification/test_bus_width_idle_config.sv */
// Self-checking bench for the bus width and idle configuration block
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_bus_width_idle_config;
	localparam int HALF = 2;
	logic mclk_i = 0, rst_i = 1, manual_rst_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic acc_req_i = 0, acc_write_i = 0, slow = 0;
	logic [3:0] avs_address_i = 0, avs_byteenable_i = 0;
	logic [31:0] avs_writedata_i = 0, seed = 32'h8b09942d;
	logic [2:0] acc_area_i = 0;
	logic [1:0] wid_seen;
	logic [6:0] cs_seen;
	logic [15:0] mdl [3];
	wire [31:0] avs_readdata_o;
	wire [6:0] chip_select_n_o;
	wire [1:0] access_width_o;
	wire avs_waitrequest_o, acc_ack_o, bus_clock_out_o, read_strobe_n_o, write_strobe_n_o;
	wire wait_n_i, upe, rsv;
	int bad_count = 0, total_checks = 0, hi = 0, lo = 0, gap_seen = 0, len_seen = 0;
	always #2 mclk_i = ~mclk_i;
	bus_width_idle_config #(.CLK_HALF(HALF)) u_bus_width_idle_config (.mclk_i, .rst_i,
		.manual_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .acc_req_i, .acc_area_i,
		.acc_write_i, .acc_ack_o, .bus_clock_out_o, .chip_select_n_o, .read_strobe_n_o,
		.write_strobe_n_o, .wait_n_i, .access_width_o, .upper_byte_port_enable_o(upe),
		.data_lines_23_to_16_bus_o(), .width_reserved_o(rsv), .width_initialised_o());
	ext_memory_model u_ext_memory_model (.bus_clock_out_i(bus_clock_out_o),
		.chip_select_n_i(chip_select_n_o), .slow_i(slow), .wait_n_o(wait_n_i));
	// Strobe idle and active spans, sampled away from the launching edge
	always @(negedge mclk_i) begin
		if (read_strobe_n_o & write_strobe_n_o) begin
			if (lo) len_seen = lo;
			lo = 0;
			hi++;
		end else begin
			if (hi) gap_seen = hi;
			wid_seen = access_width_o;
			cs_seen = chip_select_n_o;
			hi = 0;
			lo++;
		end
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function int idle(int c);
		c = c & 3;
		return c < 2 ? 1 : c;
	endfunction
	task complete_run;
		$display("mismatches %0d of %0d checks", bad_count, total_checks);
		if (bad_count == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task bus(input bit w, input logic [3:0] a, input logic [15:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= {16'h0, d};
		avs_byteenable_i <= be;
		avs_read_i <= !w;
		avs_write_i <= w;
		do begin @(posedge mclk_i); end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 0;
		avs_write_i <= 0;
	endtask
	task wr(input int i, input logic [15:0] d, input logic [3:0] be);
		logic [31:0] q;
		logic [15:0] m;
		m = (i == 0 ? 16'h3ffd : i == 1 ? 16'hbfff : 16'h0) & {{8{be[1]}}, {8{be[0]}}};
		mdl[i] = (mdl[i] & ~m) | (d & m);
		bus(1, 4'(i * 4), d, be, q);
	endtask
	task chk_all;
		logic [31:0] q;
		logic [1:0] c;
		bit r;
		for (int i = 0; i < 3; i++) begin
			bus(0, 4'(i * 4), 16'h0, 4'hf, q);
			`CHK("register", {16'h0, mdl[i]}, q)
		end
		r = 0;
		for (int n = 1; n < 7; n++) begin
			c = 2'(mdl[0] >> (2 * n));
			r |= c == 2'h0 || (mdl[0][0] && c == 2'h3);
		end
		`CHK("reserved", r, rsv)
	endtask
	task acc(input int a, input bit w);
		acc_area_i <= 3'(a);
		acc_write_i <= w;
		acc_req_i <= 1;
		do begin @(posedge mclk_i); end while (acc_ack_o !== 1'b1);
	endtask
	task por;
		rst_i <= 1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 0;
		mdl = '{16'h3ffc, 16'h3fff, 16'h0};
	endtask
	initial begin
		#200000;
		bad_count++;
		complete_run;
	end
	initial begin
		int base, lenf, k, a, pa, pw, w;
		por;
		chk_all;
		// width register set before other areas are used
		repeat (12) begin
			a = xs() % 3;
			wr(a, xs() & 16'hfffe, 4'(xs()));
			chk_all;
		end
		wr(0, 16'h1554, 4'hf);
		wr(0, 16'h1555, 4'hf);
		@(posedge mclk_i);
		`CHK("port", 1'b1, upe)
		wr(0, xs() & 16'hfffe, 4'h3);
		@(posedge mclk_i);
		`CHK("port", 1'b0, upe)
		manual_rst_i <= 1;
		@(posedge mclk_i) manual_rst_i <= 0;
		chk_all;
		acc(0, 0);
		acc(0, 0);
		base = gap_seen;
		lenf = len_seen;
		`CHK("base gap", 2 * HALF, base)
		`CHK("base length", 2 * HALF, lenf)
		pa = 0;
		pw = 0;
		repeat (16) begin
			a = xs() % 7;
			w = xs() & 1;
			acc(a, w);
			k = (a != pa || (!pw && w)) ? idle(mdl[1] >> (2 * pa)) : 0;
			`CHK("gap", base + 2 * HALF * k, gap_seen)
			`CHK("width", a ? 2'(mdl[0] >> (2 * a)) : 2'h3, wid_seen)
			`CHK("select", ~(7'h01 << a), cs_seen)
			pa = a;
			pw = w;
		end
		acc_req_i <= 0;
		for (int e = 0; e < 2; e++) begin
			wr(1, {1'(e), mdl[1][14:0]}, 4'hf);
			slow <= 1;
			acc(pa, 0);
			acc_req_i <= 0;
			`CHK("stretch", 1'b1, len_seen > lenf)
			slow <= 0;
		end
		por;
		chk_all;
		complete_run;
	end
endmodule
